// >>> rcp_defs.svh
`ifndef RCP_DEFS_SVH
`define RCP_DEFS_SVH

// register byte offsets on the control bus
`define RCP_OFF_CTRL      8'h00
`define RCP_OFF_STATUS    8'h04
`define RCP_OFF_INT_STAT  8'h08
`define RCP_OFF_INT_MASK  8'h0C

// control register fields
`define RCP_CTRL_BANK     0
`define RCP_CTRL_CLRRES   1
`define RCP_CTRL_RESET    32'h0000_0000

// status register fields
`define RCP_ST_BUSY       0
`define RCP_ST_PASS       1
`define RCP_ST_ERROR      2
`define RCP_ST_AREA_LO    4
`define RCP_ST_PINS_LO    8

// event bits, shared by interrupt status and mask
`define RCP_EV_START      0
`define RCP_EV_CANCEL     1
`define RCP_EV_ENTER      2
`define RCP_EV_NEXT       3
`define RCP_EV_VERIFY     4
`define RCP_EV_CLEAR      5
`define RCP_EV_AREA       6
`define RCP_EV_W          7
`define RCP_INT_RESET     7'h00

// remote input vector layout after synchronising
`define RCP_PIN_CANCEL    0
`define RCP_PIN_ENTER     1
`define RCP_PIN_NEXT      2
`define RCP_PIN_VERIFY    3
`define RCP_PIN_START     4
`define RCP_PIN_CLEAR     5
`define RCP_PIN_W         6
`define RCP_PIN_IDLE      6'h3F

`endif

// >>> rcp_pkg.sv
package rcp_pkg;

	// bus answer codes
	typedef enum logic [1:0] {
		RCP_RESP_OKAY   = 2'h0,
		RCP_RESP_SLVERR = 2'h2
	} rcp_resp_t;

	// meaning of the three shared pins
	typedef enum logic {
		RCP_MODE_BUTTON = 1'h0,
		RCP_MODE_BANK   = 1'h1
	} rcp_mode_t;

endpackage

// >>> rcp_sync_edge.sv
`timescale 1ns/100ps
`include "rcp_defs.svh"

// two-flop synchroniser per pin plus a falling-edge detector
module rcp_sync_edge #(
	parameter int WIDTH = `RCP_PIN_W
)(
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] prev_reg;

	if (WIDTH < 1) begin : g_chk
		$error("rcp_sync_edge: WIDTH must be at least 1");
	end

	// idle level is high, matching pulled-up open inputs
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			meta_reg <= {WIDTH{1'b1}};
			sync_reg <= {WIDTH{1'b1}};
			prev_reg <= {WIDTH{1'b1}};
		end else begin
			meta_reg <= pinIn;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// only the second stage and its delayed copy feed logic
	assign level = sync_reg;
	assign fall  = prev_reg & ~sync_reg;
endmodule

// >>> remote_control_port.sv
`timescale 1ns/100ps
`include "rcp_defs.svh"
// Summary of operation
// - link-present output stays high whenever the device is powered
// - busy, pass and error outputs are high-active copies of the panel lamps
// - outside bank mode a low cancel pin acts as the cancel button
// - outside bank mode a low enter pin acts as the enter button
// - outside bank mode a low next pin acts as the next button
// - in bank mode cancel, enter, next form area number lsb, mid, msb
// - a low start pin issues the start command
// - a low clear-result pin clears pass and error to low
// - every remote input has a pull-up, so open inputs are inactive
module remote_control_port #(
	parameter int ADDR_W = 8,
	parameter int AREA_W = 3
)(
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	// register bus, AXI4-Lite slave
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// remote connector inputs, low active
	input  wire logic                 cancelPinN,
	input  wire logic                 enterPinN,
	input  wire logic                 nextPinN,
	input  wire logic                 verifyRequestPinN,
	input  wire logic                 startPinN,
	input  wire logic                 resultClearPinN,
	output logic [`RCP_PIN_W-1:0]     pullUpEn,
	// remote connector outputs, high active
	output logic                      linkPresent,
	output logic                      busyOut,
	output logic                      passOut,
	output logic                      errorOut,
	// front-panel lamps
	output logic                      ledBusy,
	output logic                      ledPass,
	output logic                      ledError,
	// programmer core side
	input  wire logic                 progBusy,
	input  wire logic                 progPass,
	input  wire logic                 progError,
	output logic                      cancelCmd,
	output logic                      enterCmd,
	output logic                      nextCmd,
	output logic                      verifyCmd,
	output logic                      startCmd,
	output logic                      bankMode,
	output logic [AREA_W-1:0]         areaSel,
	output logic                      irq
);
	if (AREA_W != 3 || ADDR_W < 8) begin : g_chk
		$error("remote_control_port: AREA_W must be 3 and ADDR_W at least 8");
	end
	// byte-lane merge, shared by every writable register
	function automatic logic [31:0] mergeStrobe(
		input logic [31:0] oldVal,
		input logic [31:0] newVal,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = oldVal;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = newVal[8*i +: 8];
			end
		end
		return res;
	endfunction
	// full-address compare against a register offset
	function automatic logic isAt(
		input logic [ADDR_W-1:0] addr,
		input logic [7:0]        off
	);
		return addr == ADDR_W'(off);
	endfunction
	logic [`RCP_PIN_W-1:0] pinRaw;
	logic [`RCP_PIN_W-1:0] pinLevel;
	logic [`RCP_PIN_W-1:0] pinFall;
	assign pinRaw[`RCP_PIN_CANCEL] = cancelPinN;
	assign pinRaw[`RCP_PIN_ENTER]  = enterPinN;
	assign pinRaw[`RCP_PIN_NEXT]   = nextPinN;
	assign pinRaw[`RCP_PIN_VERIFY] = verifyRequestPinN;
	assign pinRaw[`RCP_PIN_START]  = startPinN;
	assign pinRaw[`RCP_PIN_CLEAR]  = resultClearPinN;
	// pins cross in through two flops; edges come from the second stage
	rcp_sync_edge #(
		.WIDTH (`RCP_PIN_W)
	) u_sync (
		.sys_clk (sys_clk),
		.reset   (reset),
		.pinIn   (pinRaw),
		.level   (pinLevel),
		.fall    (pinFall)
	);
	// pad pull-ups tied on, so an open pin idles high and reads inactive
	assign pullUpEn = `RCP_PIN_IDLE;
	logic                awHeld_reg;
	logic                wHeld_reg;
	logic [ADDR_W-1:0]   awAddr_reg;
	logic [31:0]         wData_reg;
	logic [3:0]          wStrb_reg;
	logic                bValid_reg;
	rcp_pkg::rcp_resp_t  bResp_reg;
	logic                rValid_reg;
	logic [31:0]         rData_reg;
	rcp_pkg::rcp_resp_t  rResp_reg;
	logic [31:0]         ctrl_reg;
	logic [`RCP_EV_W-1:0] intStat_reg;
	logic [`RCP_EV_W-1:0] intMask_reg;
	// write side decode
	wire doWrite   = awHeld_reg && wHeld_reg && !bValid_reg;
	wire wHitCtrl  = isAt(awAddr_reg, `RCP_OFF_CTRL);
	wire wHitStat  = isAt(awAddr_reg, `RCP_OFF_STATUS);
	wire wHitIntSt = isAt(awAddr_reg, `RCP_OFF_INT_STAT);
	wire wHitMask  = isAt(awAddr_reg, `RCP_OFF_INT_MASK);
	wire wMapped   = wHitCtrl || wHitStat || wHitIntSt || wHitMask;
	wire [31:0] wMerged0 = mergeStrobe(32'h0000_0000, wData_reg, wStrb_reg);
	wire [31:0] ctrlNext = mergeStrobe(ctrl_reg, wData_reg, wStrb_reg);
	wire [31:0] maskNext = mergeStrobe(32'(intMask_reg), wData_reg, wStrb_reg);
	// read side decode, address stable while arvalid waits
	wire rHitCtrl  = isAt(s_axi_araddr, `RCP_OFF_CTRL);
	wire rHitStat  = isAt(s_axi_araddr, `RCP_OFF_STATUS);
	wire rHitIntSt = isAt(s_axi_araddr, `RCP_OFF_INT_STAT);
	wire rHitMask  = isAt(s_axi_araddr, `RCP_OFF_INT_MASK);
	wire rMapped   = rHitCtrl || rHitStat || rHitIntSt || rHitMask;
	wire arTake    = s_axi_arvalid && s_axi_arready;
	// address and data are taken in either order, each held until used
	assign s_axi_awready = !awHeld_reg && !bValid_reg;
	assign s_axi_wready  = !wHeld_reg && !bValid_reg;
	assign s_axi_bvalid  = bValid_reg;
	assign s_axi_bresp   = bResp_reg;
	assign s_axi_arready = !rValid_reg;
	assign s_axi_rvalid  = rValid_reg;
	assign s_axi_rdata   = rData_reg;
	assign s_axi_rresp   = rResp_reg;
	// write address and data capture
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			awHeld_reg <= 1'b0;
			wHeld_reg  <= 1'b0;
			awAddr_reg <= '0;
			wData_reg  <= 32'h0000_0000;
			wStrb_reg  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end else if (doWrite) begin
				awHeld_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end else if (doWrite) begin
				wHeld_reg <= 1'b0;
			end
		end
	end
	// write response; unmapped addresses answer slave error
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			bValid_reg <= 1'b0;
			bResp_reg  <= rcp_pkg::RCP_RESP_OKAY;
		end else if (doWrite) begin
			bValid_reg <= 1'b1;
			bResp_reg  <= wMapped ? rcp_pkg::RCP_RESP_OKAY : rcp_pkg::RCP_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bValid_reg <= 1'b0;
		end
	end
	logic busy_reg;
	logic pass_reg;
	logic error_reg;
	logic link_reg;
	logic [AREA_W-1:0] area_reg;
	logic cancelCmd_reg;
	logic enterCmd_reg;
	logic nextCmd_reg;
	logic verifyCmd_reg;
	logic startCmd_reg;
	assign bankMode = ctrl_reg[`RCP_CTRL_BANK];
	wire inBank = rcp_pkg::rcp_mode_t'(bankMode) == rcp_pkg::RCP_MODE_BANK;
	// shared pins read as area bits, high is one, no inversion
	wire areaSelLsb = pinLevel[`RCP_PIN_CANCEL];
	wire areaSelMid = pinLevel[`RCP_PIN_ENTER];
	wire areaSelMsb = pinLevel[`RCP_PIN_NEXT];
	wire [AREA_W-1:0] areaNow = {areaSelMsb, areaSelMid, areaSelLsb};
	wire areaChange = inBank && (areaNow != area_reg);
	// button commands only outside bank mode
	wire cancelEv = pinFall[`RCP_PIN_CANCEL] && !inBank;
	wire enterEv  = pinFall[`RCP_PIN_ENTER] && !inBank;
	wire nextEv   = pinFall[`RCP_PIN_NEXT] && !inBank;
	wire verifyEv = pinFall[`RCP_PIN_VERIFY];
	wire startEv  = pinFall[`RCP_PIN_START];
	wire clearEv  = pinFall[`RCP_PIN_CLEAR];
	// software can also clear the result through a write-one control bit
	wire swClear  = doWrite && wHitCtrl && wMerged0[`RCP_CTRL_CLRRES];
	wire resClear = clearEv || swClear;
	// a new result wins over a clear in the same cycle
	wire passNext  = progPass || (pass_reg && !resClear);
	wire errorNext = progError || (error_reg && !resClear);
	// control register; clear-result bit never stored
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ctrl_reg <= `RCP_CTRL_RESET;
		end else if (doWrite && wHitCtrl) begin
			ctrl_reg <= ctrlNext & (32'h1 << `RCP_CTRL_BANK);
		end
	end
	// result flags and busy, shared by lamps and remote pins
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			busy_reg  <= 1'b0;
			pass_reg  <= 1'b0;
			error_reg <= 1'b0;
			link_reg  <= 1'b1;
		end else begin
			busy_reg  <= progBusy;
			pass_reg  <= passNext;
			error_reg <= errorNext;
			link_reg  <= 1'b1;
		end
	end
	// area follows the pins in bank mode, holds its last value otherwise
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			area_reg <= '0;
		end else if (inBank) begin
			area_reg <= areaNow;
		end
	end
	// one-cycle command pulses, one per falling edge
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cancelCmd_reg <= 1'b0;
			enterCmd_reg  <= 1'b0;
			nextCmd_reg   <= 1'b0;
			verifyCmd_reg <= 1'b0;
			startCmd_reg  <= 1'b0;
		end else begin
			cancelCmd_reg <= cancelEv;
			enterCmd_reg  <= enterEv;
			nextCmd_reg   <= nextEv;
			verifyCmd_reg <= verifyEv;
			startCmd_reg  <= startEv;
		end
	end
	// lamp and remote outputs come from the very same flops
	assign linkPresent = link_reg;
	assign busyOut     = busy_reg;
	assign passOut     = pass_reg;
	assign errorOut    = error_reg;
	assign ledBusy     = busy_reg;
	assign ledPass     = pass_reg;
	assign ledError    = error_reg;
	assign cancelCmd   = cancelCmd_reg;
	assign enterCmd    = enterCmd_reg;
	assign nextCmd     = nextCmd_reg;
	assign verifyCmd   = verifyCmd_reg;
	assign startCmd    = startCmd_reg;
	assign areaSel     = area_reg;
	logic irq_reg;
	logic [`RCP_EV_W-1:0] events;
	wire  [`RCP_EV_W-1:0] w1c = (doWrite && wHitIntSt) ? wMerged0[`RCP_EV_W-1:0]
	                                                    : `RCP_INT_RESET;
	// event vector in status-bit order
	always_comb begin
		events = `RCP_INT_RESET;
		events[`RCP_EV_START]  = startEv;
		events[`RCP_EV_CANCEL] = cancelEv;
		events[`RCP_EV_ENTER]  = enterEv;
		events[`RCP_EV_NEXT]   = nextEv;
		events[`RCP_EV_VERIFY] = verifyEv;
		events[`RCP_EV_CLEAR]  = clearEv;
		events[`RCP_EV_AREA]   = areaChange;
	end
	// sticky status: a new event beats a write-one clear
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			intStat_reg <= `RCP_INT_RESET;
			intMask_reg <= `RCP_INT_RESET;
			irq_reg     <= 1'b0;
		end else begin
			intStat_reg <= (intStat_reg & ~w1c) | events;
			if (doWrite && wHitMask) begin
				intMask_reg <= maskNext[`RCP_EV_W-1:0];
			end
			irq_reg <= |(intStat_reg & intMask_reg);
		end
	end
	assign irq = irq_reg;
	logic [31:0] statusWord;
	logic [31:0] readWord;
	// status word gathers flags, area and synced pin levels
	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[`RCP_ST_BUSY]  = busy_reg;
		statusWord[`RCP_ST_PASS]  = pass_reg;
		statusWord[`RCP_ST_ERROR] = error_reg;
		statusWord[`RCP_ST_AREA_LO +: AREA_W] = area_reg;
		statusWord[`RCP_ST_PINS_LO +: `RCP_PIN_W] = pinLevel;
	end
	assign readWord = rHitCtrl  ? ctrl_reg :
	                  rHitStat  ? statusWord :
	                  rHitIntSt ? 32'(intStat_reg) :
	                  rHitMask  ? 32'(intMask_reg) : 32'h0000_0000;
	// read answer registered on the same edge that takes the address
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rValid_reg <= 1'b0;
			rData_reg  <= 32'h0000_0000;
			rResp_reg  <= rcp_pkg::RCP_RESP_OKAY;
		end else if (arTake) begin
			rValid_reg <= 1'b1;
			rData_reg  <= readWord;
			rResp_reg  <= rMapped ? rcp_pkg::RCP_RESP_OKAY : rcp_pkg::RCP_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rValid_reg <= 1'b0;
		end
	end
endmodule

// >>> rcp_checker_asserts.sv
`timescale 1ns/100ps
`include "rcp_defs.svh"

// watches connector, lamp and command ports of the remote port
module rcp_checker #(
	parameter int AREA_W = 3
)(
	input wire logic                  sys_clk,
	input wire logic                  reset,
	input wire logic                  cancelPinN,
	input wire logic                  enterPinN,
	input wire logic                  nextPinN,
	input wire logic                  startPinN,
	input wire logic                  resultClearPinN,
	input wire logic [`RCP_PIN_W-1:0] pullUpEn,
	input wire logic                  linkPresent,
	input wire logic                  busyOut,
	input wire logic                  passOut,
	input wire logic                  errorOut,
	input wire logic                  ledBusy,
	input wire logic                  ledPass,
	input wire logic                  ledError,
	input wire logic                  progBusy,
	input wire logic                  progPass,
	input wire logic                  progError,
	input wire logic                  cancelCmd,
	input wire logic                  enterCmd,
	input wire logic                  nextCmd,
	input wire logic                  verifyCmd,
	input wire logic                  startCmd,
	input wire logic                  bankMode,
	input wire logic [AREA_W-1:0]     areaSel
);
	logic              anyCmd;
	logic [AREA_W-1:0] areaPins;

	// shared pins read as area bits, no inversion
	assign anyCmd   = cancelCmd | enterCmd | nextCmd | verifyCmd | startCmd;
	assign areaPins = {nextPinN, enterPinN, cancelPinN};

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	AST_LINK: assert property (linkPresent)
		else $error("link present output low");
	AST_PULL: assert property (pullUpEn == 6'h3F)
		else $error("pull-up enable dropped");
	AST_LAMPS: assert property ({busyOut, passOut, errorOut} == {ledBusy, ledPass, ledError})
		else $error("connector status differs from lamps");
	AST_BUSY: assert property (busyOut == $past(progBusy))
		else $error("busy output does not follow core");
	AST_PASS: assert property (progPass |=> passOut)
		else $error("pass output not set");
	AST_ERR: assert property (progError |=> errorOut)
		else $error("error output not set");
	AST_START: assert property ($fell(startPinN) |-> ##[2:4] startCmd)
		else $error("start pin gave no command");
	AST_CLEAR: assert property ($fell(resultClearPinN) |-> ##[2:4] !(passOut || errorOut))
		else $error("clear pin left pass or error set");
	AST_ONCE: assert property (anyCmd |=> !anyCmd)
		else $error("command longer than one cycle");
	AST_MUTE: assert property (bankMode && $past(bankMode, 3) |-> !(cancelCmd || enterCmd || nextCmd))
		else $error("button command in bank mode");
	AST_AREA: assert property ((bankMode && $stable(areaPins))[*5] |-> areaSel == areaPins)
		else $error("area select does not match pins");

	CVR_START: cover property (startCmd);
	CVR_AREA7: cover property (bankMode && areaSel == 3'h7);
	CVR_CLEAR: cover property ($fell(passOut));
endmodule

bind remote_control_port rcp_checker #(.AREA_W(AREA_W)) chk (.*);

// >>> rcp_remote_ctrl.sv
`timescale 1ns/100ps

// automation controller at the connector; pullLow bit set means pin driven low
module rcp_remote_ctrl (
	input  wire logic [5:0] pullLow,
	input  wire logic       bankDrive,
	input  wire logic [2:0] area,
	output logic            cancelPinN,
	output logic            enterPinN,
	output logic            nextPinN,
	output logic            verifyRequestPinN,
	output logic            startPinN,
	output logic            resultClearPinN
);
	logic [5:0] pins;

	// a released pin floats up to its pull-up, so it reads inactive
	assign pins = ~pullLow;
	// area number in positive logic, lsb on cancel, msb on next
	assign cancelPinN        = bankDrive ? area[0] : pins[0];
	assign enterPinN         = bankDrive ? area[1] : pins[1];
	assign nextPinN          = bankDrive ? area[2] : pins[2];
	assign verifyRequestPinN = pins[3];
	assign startPinN         = pins[4];
	assign resultClearPinN   = pins[5];
endmodule

// >>> testbench.sv
`timescale 1ns/100ps
`include "rcp_defs.svh"

module testbench;
	logic        sys_clk, reset, progBusy, progPass, progError, bankDrive, irq, bankMode;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        cancelPinN, enterPinN, nextPinN, verifyRequestPinN, startPinN, resultClearPinN;
	logic        linkPresent, busyOut, passOut, errorOut, ledBusy, ledPass, ledError;
	logic        cancelCmd, enterCmd, nextCmd, verifyCmd, startCmd;
	logic [5:0]  pullUpEn, pullLow;
	logic [4:0]  cmdVec;
	logic [2:0]  areaSel, area;
	logic [31:0] cmdCnt [5];
	int          numErrors, totalChecks;

	remote_control_port dut (.*);
	rcp_remote_ctrl ctrl (.*);

	// command pulses in pin order, counted so a held pin shows repeats
	assign cmdVec = {startCmd, verifyCmd, nextCmd, enterCmd, cancelCmd};
	always @(posedge sys_clk) begin
		for (int i = 0; i < 5; i++) begin
			cmdCnt[i] <= reset ? 32'h0 : cmdCnt[i] + {31'h0, cmdVec[i]};
		end
	end

	// free-running 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic waitClk(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			numErrors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic endOfTest;
		if (numErrors == 0 && totalChecks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// address and data offered together, each dropped once taken
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// held well past the sync delay so repeats would show
	task automatic pulsePin(input int i);
		pullLow[i] <= 1'b1;
		waitClk(8);
		pullLow[i] <= 1'b0;
		waitClk(6);
	endtask

	// hang guard, far beyond the few hundred cycles the run needs
	initial begin
		waitClk(20000);
		numErrors++;
		endOfTest;
	end

	// main sequence
	initial begin
		{reset, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = {1'b1, 48'h0};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{progBusy, progPass, progError, bankDrive, area, pullLow} = 13'h0000;
		s_axi_wstrb = 4'hF;
		numErrors = 0;
		totalChecks = 0;
		waitClk(3);
		reset <= 1'b0;
		waitClk(2);
		check(linkPresent, 32'h1);
		check(pullUpEn, 32'h3F);
		check(cmdVec, 32'h0);
		axiWrite(`RCP_OFF_INT_MASK, 32'h7F, rr);
		for (int i = 0; i < 5; i++) begin
			pulsePin(i);
			check(cmdCnt[i], 32'h1);
		end
		axiRead(`RCP_OFF_INT_STAT, rd, rr);
		check(rd, 32'h1F);
		check(irq, 32'h1);
		progBusy <= 1'b1;
		progPass <= 1'b1;
		waitClk(1);
		progPass <= 1'b0;
		progError <= 1'b1;
		waitClk(1);
		progError <= 1'b0;
		waitClk(2);
		check({busyOut, passOut, errorOut, ledBusy, ledPass, ledError}, 32'h3F);
		pulsePin(5);
		check({busyOut, passOut, errorOut}, 32'h4);
		progBusy <= 1'b0;
		waitClk(2);
		check({busyOut, ledBusy}, 32'h0);
		// unmapped place answers with an error
		axiRead(8'h10, rd, rr);
		check(rd, 32'h0);
		check(rr, rcp_pkg::RCP_RESP_SLVERR);
		axiWrite(8'h10, 32'hFFFFFFFF, rr);
		check(rr, rcp_pkg::RCP_RESP_SLVERR);
		// masked event still latches but keeps the line low
		axiWrite(`RCP_OFF_INT_STAT, 32'h7F, rr);
		axiWrite(`RCP_OFF_INT_MASK, 32'h0, rr);
		pulsePin(4);
		check(irq, 32'h0);
		check(cmdCnt[4], 32'h2);
		axiRead(`RCP_OFF_INT_STAT, rd, rr);
		check(rd, 32'h1);
		// bank mode walks every area number
		axiWrite(`RCP_OFF_CTRL, 32'h1, rr);
		check(rr, rcp_pkg::RCP_RESP_OKAY);
		check(bankMode, 32'h1);
		bankDrive <= 1'b1;
		for (int a = 0; a < 8; a++) begin
			area <= a[2:0];
			waitClk(6);
			check(areaSel, a[2:0]);
			axiRead(`RCP_OFF_STATUS, rd, rr);
			check(rd[6:4], a[2:0]);
		end
		check(cmdCnt[0] + cmdCnt[1] + cmdCnt[2], 32'h3);
		pulsePin(3);
		check(cmdCnt[3], 32'h2);
		// button falls stay silent in bank mode; area moves and verify still latch
		axiRead(`RCP_OFF_INT_STAT, rd, rr);
		check(rd, 32'h51);
		// software clear through the control bit keeps bank mode set
		progPass <= 1'b1;
		waitClk(1);
		progPass <= 1'b0;
		waitClk(2);
		check(passOut, 32'h1);
		axiWrite(`RCP_OFF_CTRL, 32'h3, rr);
		check(passOut, 32'h0);
		axiRead(`RCP_OFF_CTRL, rd, rr);
		check(rd, 32'h1);
		check(rr, rcp_pkg::RCP_RESP_OKAY);
		endOfTest;
	end
endmodule
